// *** core/smsc_top.sv ***
// master bus status and control registers with ahb-lite slave
//
// The AHB-Lite register port is this design's own decision.
module smsc_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic eng_arb_lost,
    input wire logic eng_arb_won,
    input wire logic eng_nack,
    input wire logic eng_misplaced,
    input wire logic eng_timeout,
    input wire logic eng_stop_sent,
    input wire logic init_mode_pin,
    input wire logic init_finish,
    input wire logic init_csum_bad,
    input wire logic init_no_cfg_done,
    input wire logic init_unmapped,
    output logic arb_retry,
    output logic xact_abort,
    output logic stop_pending,
    output logic ignore_other_masters,
    output logic timeout_disable,
    output logic master_tick,
    output logic master_bus_clk,
    output logic irq
);
    // ************************************************
    // registers and nets
    // ************************************************
    logic wr_pend_ff, rd_pend_ff;
    logic [smsc_pkg::DEC_W-1:0] addr_ff;
    logic [smsc_pkg::PRESC_W-1:0] master_clock_prescale;
    logic skip_checksum_check;
    logic eeprom_init_complete;
    logic [smsc_pkg::ERR_W-1:0] err_ff, err_set, err_clr;
    logic [smsc_pkg::EVT_W-1:0] ist_ff, imask_ff, evt_set;
    logic mode_s1_ff, mode_s2_ff, done_set, csum_set, boot_ff;
    logic [31:0] hrdata_ff;
    logic accept;
    smsc_evt_if ev ();

    function automatic logic hit(input logic [smsc_pkg::DEC_W-1:0] a, input logic [smsc_pkg::DEC_W-1:0] off);
        hit = a == off;
    endfunction : hit

    // ************************************************
    // ahb-lite slave
    // ************************************************
    // writes finish with no wait; reads insert one wait so a write just before is visible
    assign accept = hsel && hready && htrans[1];
    assign hreadyout = !rd_pend_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_ff <= '0;
        end else begin
            wr_pend_ff <= accept && hwrite;
            rd_pend_ff <= accept && !hwrite;
            if (accept) begin
                addr_ff <= haddr[smsc_pkg::DEC_W-1:0];
            end
        end
    end

    // read data captured in the wait cycle; unmapped reads return zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= '0;
        end else if (rd_pend_ff) begin
            hrdata_ff <= '0;
            if (hit(addr_ff, smsc_pkg::STS_OFF)) begin
                hrdata_ff[smsc_pkg::STS_DONE_BIT] <= eeprom_init_complete;
                hrdata_ff[smsc_pkg::STS_ERR_LSB +: smsc_pkg::ERR_W] <= err_ff;
            end else if (hit(addr_ff, smsc_pkg::CTL_OFF)) begin
                hrdata_ff[smsc_pkg::CTL_PRESC_LSB +: smsc_pkg::PRESC_W] <= master_clock_prescale;
                hrdata_ff[smsc_pkg::CTL_IOM_BIT] <= ignore_other_masters;
                hrdata_ff[smsc_pkg::CTL_SKIP_BIT] <= skip_checksum_check;
                hrdata_ff[smsc_pkg::CTL_TODIS_BIT] <= timeout_disable;
            end else if (hit(addr_ff, smsc_pkg::IST_OFF)) begin
                hrdata_ff[smsc_pkg::EVT_W-1:0] <= ist_ff;
            end else if (hit(addr_ff, smsc_pkg::IMSK_OFF)) begin
                hrdata_ff[smsc_pkg::EVT_W-1:0] <= imask_ff;
            end
        end
    end

    // ************************************************
    // control register
    // ************************************************
    // prescale comes up at the boot value so the bus runs at 100 kHz before software touches it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            master_clock_prescale <= smsc_pkg::PRESC_RST;
            ignore_other_masters <= 1'b0;
            skip_checksum_check <= 1'b0;
            timeout_disable <= 1'b0;
        end else if (wr_pend_ff && hit(addr_ff, smsc_pkg::CTL_OFF)) begin
            master_clock_prescale <= hwdata[smsc_pkg::CTL_PRESC_LSB +: smsc_pkg::PRESC_W];
            ignore_other_masters <= hwdata[smsc_pkg::CTL_IOM_BIT];
            skip_checksum_check <= hwdata[smsc_pkg::CTL_SKIP_BIT];
            timeout_disable <= hwdata[smsc_pkg::CTL_TODIS_BIT];
        end
    end

    // ************************************************
    // initialization events
    // ************************************************
    // init mode is a strap pin, so it is synchronised before use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_s1_ff <= 1'b0;
            mode_s2_ff <= 1'b0;
        end else begin
            mode_s1_ff <= init_mode_pin;
            mode_s2_ff <= mode_s1_ff;
        end
    end

    always_comb begin
        csum_set = (init_csum_bad && !skip_checksum_check) || init_no_cfg_done;
        done_set = mode_s2_ff && (init_finish || csum_set || init_unmapped);
        err_set = {init_unmapped, csum_set, ev.err_frame, ev.err_arb, ev.err_nack};
        err_clr = '0;
        if (wr_pend_ff && hit(addr_ff, smsc_pkg::STS_OFF)) begin
            err_clr = hwdata[smsc_pkg::STS_ERR_LSB +: smsc_pkg::ERR_W];
        end
        evt_set = {done_set && !eeprom_init_complete, err_set};
    end

    // ************************************************
    // status register
    // ************************************************
    // write-one-clear error flags; a set in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_ff <= '0;
            eeprom_init_complete <= 1'b0;
        end else begin
            err_ff <= (err_ff & ~err_clr) | err_set;
            if (done_set) begin
                eeprom_init_complete <= 1'b1;
            end
        end
    end

    // ************************************************
    // interrupts
    // ************************************************
    // sticky events cleared by reading; set wins over the read-clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ist_ff <= '0;
        end else if (rd_pend_ff && hit(addr_ff, smsc_pkg::IST_OFF)) begin
            ist_ff <= evt_set;
        end else begin
            ist_ff <= ist_ff | evt_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            imask_ff <= '0;
        end else if (wr_pend_ff && hit(addr_ff, smsc_pkg::IMSK_OFF)) begin
            imask_ff <= hwdata[smsc_pkg::EVT_W-1:0];
        end
    end

    assign irq = |(ist_ff & imask_ff);

    // ************************************************
    // engine events and submodules
    // ************************************************
    assign ev.arb_lost = eng_arb_lost;
    assign ev.arb_won = eng_arb_won;
    assign ev.nack = eng_nack;
    assign ev.misplaced = eng_misplaced;
    assign ev.timeout = eng_timeout;
    assign ev.stop_sent = eng_stop_sent;
    assign ev.ignore_masters = ignore_other_masters;
    assign ev.timeout_dis = timeout_disable;
    assign arb_retry = ev.arb_retry;
    assign xact_abort = ev.xact_abort;
    assign stop_pending = ev.stop_pend;

    smsc_arb u_arb (
        .hclk(hclk),
        .hresetn(hresetn),
        .ev(ev)
    );

    smsc_prescale #(.PW(smsc_pkg::PRESC_W)) u_presc (
        .hclk(hclk),
        .hresetn(hresetn),
        .prescale(master_clock_prescale),
        .tick(master_tick),
        .bus_clk(master_bus_clk)
    );

    // ************************************************
    // checks
    // ************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_ff <= 1'b0;
        end else begin
            boot_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_init_done_set: assert property (mode_s2_ff && init_finish |=> eeprom_init_complete)
        else $error("init complete not set");
    a_nack_flag: assert property (eng_nack |=> ##1 err_ff[0])
        else $error("nack flag not set");
    a_frame_flag: assert property (eng_misplaced |=> ##1 err_ff[2])
        else $error("framing flag not set");
    a_csum_flag: assert property (init_no_cfg_done || (init_csum_bad && !skip_checksum_check) |=> err_ff[3])
        else $error("checksum flag not set");
    a_skip_csum: assert property (!err_ff[3] && !init_no_cfg_done && skip_checksum_check |=> !err_ff[3])
        else $error("checksum error not ignored");
    a_unmap_flag: assert property (init_unmapped |=> err_ff[4] && ist_ff[4])
        else $error("unmapped flag not set");
    a_boot_prescale: assert property (!boot_ff |-> master_clock_prescale == smsc_pkg::PRESC_RST)
        else $error("prescale not at boot value");

    c_arb_abort: cover property (ev.err_arb ##1 eng_stop_sent);
    c_irq_read: cover property (irq ##[1:20] rd_pend_ff && hit(addr_ff, smsc_pkg::IST_OFF));
    c_w1c_race: cover property (|(err_clr & err_set));
endmodule : smsc_top

// *** inc/smsc_pkg.sv ***
// constants shared by the master bus status and control block
package smsc_pkg;
    // ************************************************
    // register map (byte addresses, low 12 bits decoded)
    // ************************************************
    localparam logic [11:0] STS_OFF = 12'h344;
    localparam logic [11:0] CTL_OFF = 12'h348;
    localparam logic [11:0] IST_OFF = 12'h380;
    localparam logic [11:0] IMSK_OFF = 12'h384;
    localparam int DEC_W = 12;
    // ************************************************
    // status fields
    // ************************************************
    localparam int STS_DONE_BIT = 24;
    localparam int STS_ERR_LSB = 25;
    localparam int ERR_W = 5;
    localparam int EVT_W = 6;
    // ************************************************
    // control fields
    // ************************************************
    localparam int CTL_PRESC_LSB = 0;
    localparam int PRESC_W = 16;
    localparam int CTL_IOM_BIT = 16;
    localparam int CTL_SKIP_BIT = 17;
    localparam int CTL_TODIS_BIT = 22;
    localparam logic [15:0] PRESC_RST = 16'h0139;
    // ************************************************
    // timing
    // ************************************************
    localparam int PRESC_UNIT_NS = 32;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ARB_LIMIT = 16;
endpackage : smsc_pkg

// *** inc/smsc_evt_if.sv ***
// events between the master shift engine port and the arbitration tracker
interface smsc_evt_if;
    logic arb_lost;
    logic arb_won;
    logic nack;
    logic misplaced;
    logic timeout;
    logic stop_sent;
    logic ignore_masters;
    logic timeout_dis;
    logic arb_retry;
    logic xact_abort;
    logic stop_pend;
    logic err_nack;
    logic err_arb;
    logic err_frame;
    modport core (output arb_lost, arb_won, nack, misplaced, timeout, stop_sent, ignore_masters, timeout_dis,
                  input arb_retry, xact_abort, stop_pend, err_nack, err_arb, err_frame);
    modport arb (input arb_lost, arb_won, nack, misplaced, timeout, stop_sent, ignore_masters, timeout_dis,
                 output arb_retry, xact_abort, stop_pend, err_nack, err_arb, err_frame);
endinterface : smsc_evt_if

// *** core/smsc_prescale.sv ***
// master bus clock prescaler: period of 32 ns times the programmed value
module smsc_prescale #(
    parameter int PW = smsc_pkg::PRESC_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [PW-1:0] prescale,
    output logic tick,
    output logic bus_clk
);
    localparam int AW = PW + 6;
    localparam logic [AW-1:0] STEP = AW'(smsc_pkg::CLK_PERIOD_NS);
    logic [AW-1:0] acc_ff, nxt_acc, limit, sum;
    logic running, nxt_tick;

    // fractional accumulator: 10 ns per hclk against 32 ns units, so jitter stays within one hclk
    always_comb begin
        limit = AW'(prescale) * AW'(smsc_pkg::PRESC_UNIT_NS);
        running = prescale > PW'(1);
        sum = acc_ff + STEP;
        nxt_tick = 1'b0;
        nxt_acc = sum;
        if (!running) begin
            nxt_acc = '0;
        end else if (sum >= limit) begin
            nxt_acc = sum - limit;
            nxt_tick = 1'b1;
        end
    end

    // clock held high (bus idle level) while stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_ff <= '0;
            tick <= 1'b0;
            bus_clk <= 1'b1;
        end else begin
            acc_ff <= nxt_acc;
            tick <= nxt_tick;
            bus_clk <= !running || (nxt_acc < (limit >> 1));
        end
    end

    // ************************************************
    // checks
    // ************************************************
    logic [AW-1:0] gap_ff;
    logic seen_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_ff <= '0;
            seen_ff <= 1'b0;
        end else begin
            gap_ff <= tick ? AW'(1) : gap_ff + AW'(1);
            seen_ff <= (seen_ff || tick) && running && $stable(prescale);
        end
    end

    a_presc_period: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && seen_ff && running && $stable(prescale) |->
        (gap_ff * STEP + STEP >= limit) && (gap_ff * STEP <= limit + STEP))
        else $error("prescaled period off");
    a_presc_stop: assert property (@(posedge hclk) disable iff (!hresetn)
        !running [*2] |-> !tick && bus_clk)
        else $error("clock runs with prescale below two");
endmodule : smsc_prescale

// *** core/smsc_arb.sv ***
// arbitration retry, abort and stop tracking for the master interface
module smsc_arb (
    input wire logic hclk,
    input wire logic hresetn,
    smsc_evt_if.arb ev
);
    logic [4:0] lost_cnt_ff;
    logic lost_hit, last_try, err_any;

    always_comb begin
        lost_hit = ev.arb_lost && !ev.ignore_masters;
        last_try = lost_cnt_ff == 5'(smsc_pkg::ARB_LIMIT - 1);
        err_any = ev.nack || ev.misplaced || (ev.timeout && !ev.timeout_dis);
    end

    // consecutive losses; a win or an abort starts the count again
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lost_cnt_ff <= '0;
        end else if (ev.arb_won || err_any || (lost_hit && last_try)) begin
            lost_cnt_ff <= '0;
        end else if (lost_hit) begin
            lost_cnt_ff <= lost_cnt_ff + 5'h01;
        end
    end

    // one-cycle answers to the engine and error pulses to the status flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ev.arb_retry <= 1'b0;
            ev.xact_abort <= 1'b0;
            ev.err_nack <= 1'b0;
            ev.err_arb <= 1'b0;
            ev.err_frame <= 1'b0;
        end else begin
            ev.arb_retry <= lost_hit && !last_try && !err_any;
            ev.xact_abort <= err_any || (lost_hit && last_try);
            ev.err_nack <= ev.nack;
            ev.err_arb <= lost_hit && last_try && !err_any;
            ev.err_frame <= ev.misplaced;
        end
    end

    // bus must be released with a stop before the next start; a new abort wins over stop_sent
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ev.stop_pend <= 1'b0;
        end else if (err_any || (lost_hit && last_try)) begin
            ev.stop_pend <= 1'b1;
        end else if (ev.stop_sent) begin
            ev.stop_pend <= 1'b0;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    a_arb_retry_auto: assert property (@(posedge hclk) disable iff (!hresetn)
        lost_hit && !last_try && !err_any |=> ev.arb_retry && !ev.xact_abort)
        else $error("lost arbitration not retried");
    a_arb_abort_limit: assert property (@(posedge hclk) disable iff (!hresetn)
        ev.err_arb |-> $past(lost_cnt_ff) == 5'(smsc_pkg::ARB_LIMIT - 1) && ev.xact_abort)
        else $error("abort not on sixteenth loss");
    a_arb_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
        ev.ignore_masters && !ev.nack && !ev.misplaced && !ev.timeout |=> !ev.xact_abort && !ev.arb_retry)
        else $error("arbitration acted on while ignoring masters");
    a_timeout_off: assert property (@(posedge hclk) disable iff (!hresetn)
        ev.timeout_dis && !ev.nack && !ev.misplaced && !(lost_hit && last_try) |=> !ev.xact_abort)
        else $error("timeout applied while disabled");
    a_stop_after_err: assert property (@(posedge hclk) disable iff (!hresetn)
        ev.xact_abort |-> ev.stop_pend)
        else $error("abort without stop pending");
endmodule : smsc_arb

// *** sim/smsc_eng_model.sv ***
// engine-side model: turns bench event requests into pulses and answers pending stops
module smsc_eng_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [4:0] ev_req,
    input wire logic stop_pending,
    output logic eng_arb_lost,
    output logic eng_arb_won,
    output logic eng_nack,
    output logic eng_misplaced,
    output logic eng_timeout,
    output logic eng_stop_sent
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_ff;
    // one pulse per requested event, launched on the edge after the request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {eng_timeout, eng_misplaced, eng_nack, eng_arb_won, eng_arb_lost} <= 5'h00;
        end else begin
            {eng_timeout, eng_misplaced, eng_nack, eng_arb_won, eng_arb_lost} <= ev_req;
        end
    end
    // stop goes out a few cycles late, like a slow bus release, so pending is seen held
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_ff <= 2'h0;
            eng_stop_sent <= 1'b0;
        end else begin
            eng_stop_sent <= 1'b0;
            if (stop_pending && !eng_stop_sent) begin
                wait_ff <= wait_ff + 2'h1;
                if (wait_ff == 2'h3) begin
                    eng_stop_sent <= 1'b1;
                    wait_ff <= 2'h0;
                end
            end
        end
    end
endmodule : smsc_eng_model

// *** sim/tb.sv ***
// self-checking bench for the master bus status and control block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, init_mode_pin;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [8:0] req;
    logic eng_arb_lost, eng_arb_won, eng_nack, eng_misplaced, eng_timeout, eng_stop_sent;
    logic arb_retry, xact_abort, stop_pending, ignore_other_masters, timeout_disable;
    logic master_tick, master_bus_clk, irq;
    int n_mismatch = 0, samples_checked = 0, cyc_count = 0, n_tick = 0, n_retry = 0, n_abort = 0;
    localparam logic [31:0] STS = 32'h00000344;
    localparam logic [31:0] CTL = 32'h00000348;
    localparam logic [31:0] IST = 32'h00000380;
    localparam logic [31:0] IMSK = 32'h00000384;
    localparam logic [31:0] CTL_DEF = 32'h00000139;
    assign hready = hreadyout;
    smsc_top smsc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .eng_arb_lost(eng_arb_lost), .eng_arb_won(eng_arb_won), .eng_nack(eng_nack),
        .eng_misplaced(eng_misplaced), .eng_timeout(eng_timeout), .eng_stop_sent(eng_stop_sent),
        .init_mode_pin(init_mode_pin), .init_finish(req[5]), .init_csum_bad(req[6]),
        .init_no_cfg_done(req[7]), .init_unmapped(req[8]), .arb_retry(arb_retry), .xact_abort(xact_abort),
        .stop_pending(stop_pending), .ignore_other_masters(ignore_other_masters),
        .timeout_disable(timeout_disable), .master_tick(master_tick), .master_bus_clk(master_bus_clk), .irq(irq));
    smsc_eng_model smsc_eng_model_i (.hclk(hclk), .hresetn(hresetn), .ev_req(req[4:0]),
        .stop_pending(stop_pending), .eng_arb_lost(eng_arb_lost), .eng_arb_won(eng_arb_won),
        .eng_nack(eng_nack), .eng_misplaced(eng_misplaced), .eng_timeout(eng_timeout),
        .eng_stop_sent(eng_stop_sent));
    // ************************************************
    // clock, watchdog and output monitors
    // ************************************************
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // a hang counts as a mismatch and ends the run through the normal report
    always @(posedge hclk) begin
        cyc_count++;
        if (cyc_count == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    // counted on the falling edge so clearing a counter never races the clock edge
    always @(negedge hclk) begin
        if (master_tick === 1'b1) n_tick++;
        if (arb_retry === 1'b1) n_retry++;
        if (xact_abort === 1'b1) n_abort++;
    end
    // ************************************************
    // bus tasks
    // ************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] unused;
        xfer(1'b1, a, d, unused);
    endtask : wr
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        xfer(1'b0, a, 32'h00000000, v);
        check(v, exp);
    endtask : rdchk
    // bits 4:0 are engine events, 8:5 are init events
    task automatic pulse(input int b, input int n = 1);
        repeat (n) begin
            req <= 9'h001 << b;
            @(posedge hclk);
            req <= 9'h000;
            @(posedge hclk);
        end
        repeat (8) @(posedge hclk);
    endtask : pulse
    task automatic close_out();
        if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; req = 9'h000; init_mode_pin = 1'b1;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(CTL, CTL_DEF);
        rdchk(STS, 32'h00000000);
        rdchk(32'h00000390, 32'h00000000);
        // ten units of 32 ns make exactly 32 cycles a period
        wr(CTL, 32'h0000000a);
        repeat (40) @(posedge hclk);
        n_tick = 0;
        repeat (320) @(posedge hclk);
        check(n_tick, 32'd10);
        for (int v = 0; v < 2; v++) begin
            wr(CTL, v);
            repeat (40) @(posedge hclk);
            n_tick = 0;
            repeat (100) @(posedge hclk);
            check(n_tick, 32'd0);
            check(master_bus_clk, 1'b1);
        end
        wr(CTL, CTL_DEF);
        wr(IMSK, 32'h0000003f);
        // fifteen losses only retry; the sixteenth aborts and flags
        n_retry = 0;
        n_abort = 0;
        pulse(0, 15);
        check(n_retry, 32'd15);
        check(n_abort, 32'd0);
        pulse(0);
        check(n_abort, 32'd1);
        check(stop_pending, 1'b0);
        rdchk(STS, 32'h1 << 26);
        check(irq, 1'b1);
        wr(STS, 32'h1 << 26);
        rdchk(STS, 32'h00000000);
        // a win in between restarts the consecutive count
        pulse(0, 8);
        pulse(1);
        pulse(0, 15);
        check(n_abort, 32'd1);
        pulse(0);
        check(n_abort, 32'd2);
        wr(STS, 32'h1 << 26);
        wr(CTL, CTL_DEF | (32'h1 << 16) | (32'h1 << 22));
        @(posedge hclk);
        check(ignore_other_masters, 1'b1);
        check(timeout_disable, 1'b1);
        n_retry = 0;
        pulse(0, 16);
        pulse(4);
        check(n_retry, 32'd0);
        check(n_abort, 32'd2);
        wr(CTL, CTL_DEF);
        pulse(4);
        check(n_abort, 32'd3);
        // nack and misplaced start or stop each abort and set their own flag
        pulse(2);
        rdchk(STS, 32'h1 << 25);
        wr(STS, 32'h1 << 25);
        pulse(3);
        rdchk(STS, 32'h1 << 27);
        wr(STS, 32'hffffffff);
        rdchk(STS, 32'h00000000);
        check(n_abort, 32'd5);
        // init events: skipped checksum, missing done, unmapped load
        wr(CTL, CTL_DEF | (32'h1 << 17));
        pulse(6);
        rdchk(STS, 32'h00000000);
        pulse(7);
        rdchk(STS, (32'h1 << 24) | (32'h1 << 28));
        wr(CTL, CTL_DEF);
        wr(STS, 32'h1 << 28);
        pulse(6);
        rdchk(STS, (32'h1 << 24) | (32'h1 << 28));
        wr(STS, 32'h1 << 28);
        pulse(8);
        rdchk(STS, (32'h1 << 24) | (32'h1 << 29));
        wr(STS, 32'hffffffff);
        pulse(5);
        rdchk(STS, 32'h1 << 24);
        // interrupt: read clears, mask hides, unmask shows the sticky bit
        wr(IMSK, 32'h00000000);
        rdchk(IMSK, 32'h00000000);
        rdchk(IST, 32'h0000003f);
        pulse(2);
        check(irq, 1'b0);
        wr(IMSK, 32'h0000003f);
        @(posedge hclk);
        check(irq, 1'b1);
        wr(STS, 32'hffffffff);
        rdchk(IST, 32'h00000001);
        rdchk(IST, 32'h00000000);
        check(irq, 1'b0);
        close_out();
    end
endmodule : tb
